// >>> crsi_defines.svh
`ifndef CRSI_DEFINES_SVH
`define CRSI_DEFINES_SVH

// register file
`define CRSI_NUM_REGS 32
`define CRSI_REG_LAST 8'h1F
`define CRSI_PTR_X 5'h1A
`define CRSI_PTR_Y 5'h1C
`define CRSI_PTR_Z 5'h1E

// i/o addresses of stack pointer bytes
`define CRSI_IO_SPL 6'h3D
`define CRSI_IO_SPH 6'h3E

// top of data sram, stack pointer reset value
`define CRSI_SRAM_TOP 16'h08FF

// core flags register: global enable position
`define CRSI_GIE_BIT 7

// interrupt sources; index 0 is the lowest vector, so highest priority
`define CRSI_NUM_IRQ 8
`define CRSI_VEC_STEP 16'h0002
`define CRSI_VEC_FIRST 16'h0002

// timing in core clock cycles
`define CRSI_ENTRY_CYCLES 4
`define CRSI_WAKE_CYCLES 4
`define CRSI_RETURN_CYCLES 2

`endif

// >>> crsi_pkg.sv
package crsi_pkg;
    typedef enum logic [2:0] {
        CRSI_SP_NONE,
        CRSI_SP_PUSH,
        CRSI_SP_POP,
        CRSI_SP_CALL,
        CRSI_SP_RET,
        CRSI_SP_HANDLER_EXIT
    } crsi_spop_t;

    typedef enum logic [1:0] {
        CRSI_WR_NONE,
        CRSI_WR_BYTE,
        CRSI_WR_WORD
    } crsi_wrmode_t;
endpackage

// >>> crsi_regfile.sv
`timescale 1ns/10ps
`default_nettype none
`include "crsi_defines.svh"

// 32x8 working registers; two byte read ports plus a word read port,
// one byte or word write port, all within one cycle
module crsi_regfile
    import crsi_pkg::*;
(
    input wire logic clk,
    input wire logic rstN,
    input wire logic [4:0] rdAddrA,
    input wire logic [4:0] rdAddrB,
    output logic [7:0] rdDataA,
    output logic [7:0] rdDataB,
    output logic [15:0] rdWord,
    input wire crsi_wrmode_t wrMode,
    input wire logic [4:0] wrAddr,
    input wire logic [15:0] wrData,
    output logic [15:0] ptrX,
    output logic [15:0] ptrY,
    output logic [15:0] ptrZ
);
    logic [7:0] regs [0:`CRSI_NUM_REGS-1];
    logic [4:0] wrAddrEven;
    logic [4:0] rdAddrHi;

    assign wrAddrEven = {wrAddr[4:1], 1'b0};
    assign rdAddrHi = {rdAddrA[4:1], 1'b1};

    // reads are combinational so an alu op reads and writes in one cycle
    assign rdDataA = regs[rdAddrA];
    assign rdDataB = regs[rdAddrB];
    assign rdWord = {regs[rdAddrHi], regs[{rdAddrA[4:1], 1'b0}]};
    assign ptrX = {regs[`CRSI_PTR_X + 5'h01], regs[`CRSI_PTR_X]};
    assign ptrY = {regs[`CRSI_PTR_Y + 5'h01], regs[`CRSI_PTR_Y]};
    assign ptrZ = {regs[`CRSI_PTR_Z + 5'h01], regs[`CRSI_PTR_Z]};

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            for (int i = 0; i < `CRSI_NUM_REGS; i++)
            begin
                regs[i] <= 8'h00;
            end
        end
        else
        begin
            unique case (wrMode)
                CRSI_WR_BYTE:
                begin
                    regs[wrAddr] <= wrData[7:0];
                end
                CRSI_WR_WORD:
                begin
                    // low byte at the even address
                    regs[wrAddrEven] <= wrData[7:0];
                    regs[wrAddrEven + 5'h01] <= wrData[15:8];
                end
                CRSI_WR_NONE:
                begin
                end
                default:
                begin
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> crsi_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "crsi_defines.svh"

module crsi_core
    import crsi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    // operand / alu register ports
    input wire logic [4:0] rdAddrA,
    input wire logic [4:0] rdAddrB,
    output logic [7:0] rdDataA,
    output logic [7:0] rdDataB,
    output logic [15:0] rdWord,
    input wire crsi_wrmode_t wrMode,
    input wire logic [4:0] wrAddr,
    input wire logic [15:0] wrData,
    output logic [15:0] ptrX,
    output logic [15:0] ptrY,
    output logic [15:0] ptrZ,
    // data-space access to the working registers
    input wire logic dsRead,
    input wire logic dsWrite,
    input wire logic [15:0] dsAddr,
    input wire logic [7:0] dsWrData,
    output logic dsHit,
    output logic [7:0] dsRdData,
    // i/o port for stack pointer bytes
    input wire logic ioWrite,
    input wire logic [5:0] ioAddr,
    input wire logic [7:0] ioWrData,
    output logic [7:0] ioRdData,
    // stack operations from the decoder
    input wire crsi_spop_t spOp,
    input wire logic [15:0] pcNow,
    input wire logic [7:0] pushData,
    output logic [15:0] stackPtr,
    output logic stackWrite,
    output logic [15:0] stackAddr,
    output logic [7:0] stackWrData,
    // global enable / core flags register bit 7
    input wire logic unmaskAllOp,
    input wire logic maskAllOp,
    input wire logic flagsWrite,
    input wire logic [7:0] flagsWrData,
    output logic globalEnable,
    // interrupt sources
    input wire logic [`CRSI_NUM_IRQ-1:0] irqIsLevel,
    input wire logic [`CRSI_NUM_IRQ-1:0] irqEnable,
    input wire logic [`CRSI_NUM_IRQ-1:0] irqEvent,
    input wire logic [`CRSI_NUM_IRQ-1:0] irqLevel,
    input wire logic flagClrWrite,
    input wire logic [`CRSI_NUM_IRQ-1:0] flagClrData,
    output logic [`CRSI_NUM_IRQ-1:0] irqFlags,
    // vector relocation
    input wire logic vectorRelocateSelect,
    input wire logic [7:0] vectorTableBase,
    // sequencing with the core
    input wire logic instrBoundary,
    input wire logic coreSleeping,
    output logic irqBusy,
    output logic pcLoad,
    output logic [15:0] pcLoadValue,
    output logic [$clog2(`CRSI_NUM_IRQ)-1:0] irqAckIndex
);
    typedef enum logic [2:0] {
        CRSI_IDLE,
        CRSI_WAKE,
        CRSI_ENTRY,
        CRSI_RETURN,
        CRSI_HOLD
    } crsi_irqst_t;

    localparam int IRQ_W = $clog2(`CRSI_NUM_IRQ);

    logic rstSync1;
    logic rstSync2;
    logic rstN;
    logic [`CRSI_NUM_IRQ-1:0] evSync1;
    logic [`CRSI_NUM_IRQ-1:0] evSync2;
    logic [`CRSI_NUM_IRQ-1:0] evPrev;
    logic [`CRSI_NUM_IRQ-1:0] lvSync1;
    logic [`CRSI_NUM_IRQ-1:0] lvSync2;
    logic [`CRSI_NUM_IRQ-1:0] evRise;
    logic [`CRSI_NUM_IRQ-1:0] pending;
    logic [`CRSI_NUM_IRQ-1:0] ackClear;
    logic [IRQ_W-1:0] winIndex;
    logic winValid;
    crsi_irqst_t state;
    logic [2:0] cycleCount;
    logic [15:0] retLow;
    logic [15:0] vecAddr;
    logic [15:0] sp;
    logic dsRegHit;
    crsi_wrmode_t rfWrMode;
    logic [4:0] rfWrAddr;
    logic [15:0] rfWrData;
    logic gieBlocked;

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end
        else
        begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end
    assign rstN = rstSync2;

    // interrupt pins come from peripherals on other clocks: synchronise
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            evSync1 <= '0;
            evSync2 <= '0;
            evPrev <= '0;
            lvSync1 <= '0;
            lvSync2 <= '0;
        end
        else
        begin
            evSync1 <= irqEvent;
            evSync2 <= evSync1;
            evPrev <= evSync2;
            lvSync1 <= irqLevel;
            lvSync2 <= lvSync1;
        end
    end
    assign evRise = evSync2 & ~evPrev & ~irqIsLevel;

    // data-space mapping of working registers
    assign dsRegHit = (dsAddr <= {8'h00, `CRSI_REG_LAST});
    assign dsHit = (dsRead | dsWrite) & dsRegHit;
    assign dsRdData = rdDataA;

    // data-space write takes the write port; decoder avoids same-cycle use
    always_comb
    begin
        rfWrMode = wrMode;
        rfWrAddr = wrAddr;
        rfWrData = wrData;
        if (dsWrite && dsRegHit)
        begin
            rfWrMode = CRSI_WR_BYTE;
            rfWrAddr = dsAddr[4:0];
            rfWrData = {8'h00, dsWrData};
        end
    end

    crsi_regfile u_regfile (
        .clk(clk_sys),
        .rstN(rstN),
        .rdAddrA((dsRead && dsRegHit) ? dsAddr[4:0] : rdAddrA),
        .rdAddrB(rdAddrB),
        .rdDataA(rdDataA),
        .rdDataB(rdDataB),
        .rdWord(rdWord),
        .wrMode(rfWrMode),
        .wrAddr(rfWrAddr),
        .wrData(rfWrData),
        .ptrX(ptrX),
        .ptrY(ptrY),
        .ptrZ(ptrZ)
    );

    // pending: event flags or live level conditions, gated by enables
    assign pending = (irqFlags | (lvSync2 & irqIsLevel)) & irqEnable;

    // lowest index = lowest vector address = highest priority
    always_comb
    begin
        winIndex = '0;
        winValid = 1'b0;
        for (int i = `CRSI_NUM_IRQ - 1; i >= 0; i--)
        begin
            if (pending[i])
            begin
                winIndex = IRQ_W'(i);
                winValid = 1'b1;
            end
        end
    end

    // a mask-all in this very cycle blocks the take
    assign gieBlocked = maskAllOp | (flagsWrite & ~flagsWrData[`CRSI_GIE_BIT]);

    // vector: base page when relocated, otherwise low program space
    always_comb
    begin
        vecAddr = `CRSI_VEC_FIRST + 16'(winIndex) * `CRSI_VEC_STEP;
        if (vectorRelocateSelect)
        begin
            vecAddr = {vectorTableBase, 8'h00} + vecAddr;
        end
    end

    // entry/return sequencer
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            state <= CRSI_IDLE;
            cycleCount <= 3'h0;
            irqAckIndex <= '0;
            pcLoadValue <= 16'h0000;
            retLow <= 16'h0000;
        end
        else
        begin
            unique case (state)
                CRSI_IDLE:
                begin
                    // only at an instruction boundary, so multi-cycle ops finish
                    if (instrBoundary && winValid && globalEnable && !gieBlocked)
                    begin
                        irqAckIndex <= winIndex;
                        pcLoadValue <= vecAddr;
                        retLow <= pcNow;
                        cycleCount <= 3'h0;
                        state <= coreSleeping ? CRSI_WAKE : CRSI_ENTRY;
                    end
                    else if (spOp == CRSI_SP_HANDLER_EXIT)
                    begin
                        cycleCount <= 3'h0;
                        state <= CRSI_RETURN;
                    end
                end
                CRSI_WAKE:
                begin
                    cycleCount <= cycleCount + 3'h1;
                    if (cycleCount == 3'(`CRSI_WAKE_CYCLES - 1))
                    begin
                        cycleCount <= 3'h0;
                        state <= CRSI_ENTRY;
                    end
                end
                CRSI_ENTRY:
                begin
                    cycleCount <= cycleCount + 3'h1;
                    if (cycleCount == 3'(`CRSI_ENTRY_CYCLES - 1))
                    begin
                        state <= CRSI_IDLE;
                    end
                end
                CRSI_RETURN:
                begin
                    cycleCount <= cycleCount + 3'h1;
                    if (cycleCount == 3'(`CRSI_RETURN_CYCLES - 1))
                    begin
                        state <= CRSI_HOLD;
                    end
                end
                CRSI_HOLD:
                begin
                    // one main-program instruction must complete first
                    if (instrBoundary)
                    begin
                        state <= CRSI_IDLE;
                    end
                end
                default:
                begin
                    state <= CRSI_IDLE;
                end
            endcase
        end
    end

    assign irqBusy = (state != CRSI_IDLE);
    assign pcLoad = (state == CRSI_ENTRY)
        && (cycleCount == 3'(`CRSI_ENTRY_CYCLES - 1));
    assign ackClear = pcLoad
        ? (`CRSI_NUM_IRQ'(1) << irqAckIndex) : '0;

    // event flags: a new event wins over any clear in the same cycle
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            irqFlags <= '0;
        end
        else
        begin
            irqFlags <= (irqFlags
                & ~ackClear
                & ~(flagClrWrite ? flagClrData : '0))
                | evRise;
        end
    end

    // global enable, core flags bit 7
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            globalEnable <= 1'b0;
        end
        else if (state == CRSI_IDLE && instrBoundary && winValid
            && globalEnable && !gieBlocked)
        begin
            globalEnable <= 1'b0;
        end
        else if (state == CRSI_RETURN
            && cycleCount == 3'(`CRSI_RETURN_CYCLES - 1))
        begin
            globalEnable <= 1'b1;
        end
        else if (maskAllOp)
        begin
            globalEnable <= 1'b0;
        end
        else if (unmaskAllOp)
        begin
            globalEnable <= 1'b1;
        end
        else if (flagsWrite)
        begin
            globalEnable <= flagsWrData[`CRSI_GIE_BIT];
        end
    end

    // stack pointer; hardware entry/return sequencing has priority
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            sp <= `CRSI_SRAM_TOP;
        end
        else if (state == CRSI_ENTRY && cycleCount < 3'h2)
        begin
            sp <= sp - 16'h0001;
        end
        else if (state == CRSI_RETURN)
        begin
            sp <= sp + 16'h0001;
        end
        else if (ioWrite && ioAddr == `CRSI_IO_SPL)
        begin
            sp <= {sp[15:8], ioWrData};
        end
        else if (ioWrite && ioAddr == `CRSI_IO_SPH)
        begin
            sp <= {ioWrData, sp[7:0]};
        end
        else
        begin
            unique case (spOp)
                CRSI_SP_PUSH: sp <= sp - 16'h0001;
                CRSI_SP_POP: sp <= sp + 16'h0001;
                CRSI_SP_CALL: sp <= sp - 16'h0002;
                CRSI_SP_RET: sp <= sp + 16'h0002;
                default:
                begin
                end
            endcase
        end
    end
    assign stackPtr = sp;

    // i/o read mux for the stack pointer bytes
    always_comb
    begin
        ioRdData = 8'h00;
        if (ioAddr == `CRSI_IO_SPL)
        begin
            ioRdData = sp[7:0];
        end
        else if (ioAddr == `CRSI_IO_SPH)
        begin
            ioRdData = sp[15:8];
        end
    end

    // sram write for pushes: low return byte first, post-decrement
    always_comb
    begin
        stackWrite = 1'b0;
        stackAddr = sp;
        stackWrData = 8'h00;
        if (state == CRSI_ENTRY && cycleCount == 3'h0)
        begin
            stackWrite = 1'b1;
            stackWrData = retLow[7:0];
        end
        else if (state == CRSI_ENTRY && cycleCount == 3'h1)
        begin
            stackWrite = 1'b1;
            stackWrData = retLow[15:8];
        end
        else if (state == CRSI_IDLE && spOp == CRSI_SP_PUSH)
        begin
            stackWrite = 1'b1;
            stackWrData = pushData;
        end
    end
endmodule
`default_nettype wire

// >>> crsi_core_checker.sv
`timescale 1ns/10ps
`default_nettype none
module crsi_core_checker
    import crsi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [4:0] rdAddrA,
    input wire logic [15:0] rdWord,
    input wire logic [15:0] ptrX,
    input wire logic dsRead,
    input wire logic dsWrite,
    input wire logic [15:0] dsAddr,
    input wire logic dsHit,
    input wire logic ioWrite,
    input wire crsi_spop_t spOp,
    input wire logic [15:0] stackPtr,
    input wire logic stackWrite,
    input wire logic [15:0] stackAddr,
    input wire logic unmaskAllOp,
    input wire logic maskAllOp,
    input wire logic globalEnable,
    input wire logic coreSleeping,
    input wire logic irqBusy,
    input wire logic pcLoad
);
    import crsi_pkg::*;
    logic wasReti;
    logic entry;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // a handler exit also raises busy, so it must not count as an entry
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            wasReti <= 1'b0;
        else
            wasReti <= (spOp == CRSI_SP_HANDLER_EXIT);
    end
    assign entry = irqBusy && !wasReti;
    ds_map_a: assert property ((dsRead || dsWrite) |-> dsHit == (dsAddr <= 16'h001F))
        else $error("data space hit wrong");
    ptr_pair_a: assert property ((!dsRead && rdAddrA == 5'h1A) |-> rdWord == ptrX)
        else $error("pointer pair mismatch");
    push_down_a: assert property ((spOp == CRSI_SP_PUSH && !irqBusy && !ioWrite) |-> stackWrite && stackAddr == stackPtr ##1 stackPtr == $past(stackPtr) - 16'h0001)
        else $error("push wrong");
    // judged at the vector load: four cycles back is the take, or the last wake cycle when sleeping
    entry_sp_a: assert property (pcLoad |-> stackPtr == $past(stackPtr, 4) - 16'h0002)
        else $error("entry stack move wrong");
    take_gie_a: assert property ((entry && $rose(irqBusy)) |-> $past(globalEnable) && !globalEnable)
        else $error("entry enable wrong");
    entry_time_a: assert property ((entry && $rose(irqBusy) && !coreSleeping) |-> !pcLoad [*3] ##1 pcLoad)
        else $error("entry time wrong");
    wake_time_a: assert property ((entry && $rose(irqBusy) && coreSleeping) |-> ##7 pcLoad)
        else $error("wake entry time wrong");
    handler_exit_done_a: assert property ((spOp == CRSI_SP_HANDLER_EXIT && !irqBusy) |-> ##3 (globalEnable && stackPtr == $past(stackPtr, 3) + 16'h0002))
        else $error("handler exit wrong");
    mask_now_a: assert property ((maskAllOp && !irqBusy) |=> !globalEnable && !irqBusy ##1 !irqBusy)
        else $error("mask not immediate");
    unmask_a: assert property ((unmaskAllOp && !maskAllOp && !globalEnable) |=> globalEnable)
        else $error("unmask failed");
    cover property (entry && $rose(irqBusy) && coreSleeping);
    cover property (spOp == CRSI_SP_HANDLER_EXIT && !irqBusy);
    cover property (dsWrite && dsHit);
    cover property (spOp == CRSI_SP_PUSH && stackWrite);
endmodule
`default_nettype wire

// >>> crsi_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module crsi_far_model (
    input wire logic clk_sys,
    input wire logic [7:0] fire,
    output logic [7:0] irqEvent,
    input wire logic stackWrite,
    input wire logic [15:0] stackAddr,
    input wire logic [7:0] stackWrData
);
    logic [7:0] mem [0:16'h08FF];
    logic [7:0] hold = 8'h00;
    // events stay up two cycles so the sync flops cannot miss them
    always @(posedge clk_sys)
    begin
        hold <= fire;
        irqEvent <= fire | hold;
        if (stackWrite && stackAddr <= 16'h08FF)
            mem[stackAddr] <= stackWrData;
    end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import crsi_pkg::*;
    logic clk_sys, rst_n = 1'b0, dsRead = 1'b0, dsWrite = 1'b0;
    logic ioWrite = 1'b0, unmaskAllOp = 1'b0, maskAllOp = 1'b0;
    logic flagsWrite = 1'b0, flagClrWrite = 1'b0, coreSleeping = 1'b0;
    logic vectorRelocateSelect = 1'b0, instrBoundary = 1'b1;
    logic [4:0] rdAddrA = 5'h00, rdAddrB = 5'h00, wrAddr = 5'h00;
    logic [7:0] dsWrData = 8'h00, ioWrData = 8'h00, pushData = 8'h00;
    logic [7:0] flagsWrData = 8'h00, vectorTableBase = 8'h00, fire = 8'h00;
    logic [7:0] irqIsLevel = 8'h00, irqEnable = 8'h00, irqLevel = 8'h00;
    logic [7:0] flagClrData = 8'h00;
    logic [15:0] wrData = 16'h0000, dsAddr = 16'h0000, pcNow = 16'h0000;
    logic [5:0] ioAddr = 6'h00;
    crsi_spop_t spOp = CRSI_SP_NONE;
    crsi_wrmode_t wrMode = CRSI_WR_NONE;
    logic dsHit, stackWrite, globalEnable, irqBusy, pcLoad;
    logic [7:0] rdDataA, rdDataB, dsRdData, ioRdData, stackWrData;
    logic [7:0] irqEvent, irqFlags;
    logic [15:0] rdWord, ptrX, ptrY, ptrZ, stackPtr, stackAddr, pcLoadValue;
    logic [2:0] irqAckIndex;
    logic [7:0] refReg [32];
    int errors = 0;
    int tests_run = 0;
    crsi_core crsi_core_i (.clk_sys, .rst_n, .rdAddrA, .rdAddrB, .rdDataA,
        .rdDataB, .rdWord, .wrMode, .wrAddr, .wrData, .ptrX, .ptrY, .ptrZ,
        .dsRead, .dsWrite, .dsAddr, .dsWrData, .dsHit, .dsRdData, .ioWrite,
        .ioAddr, .ioWrData, .ioRdData, .spOp, .pcNow, .pushData, .stackPtr,
        .stackWrite, .stackAddr, .stackWrData, .unmaskAllOp, .maskAllOp,
        .flagsWrite, .flagsWrData, .globalEnable, .irqIsLevel, .irqEnable,
        .irqEvent, .irqLevel, .flagClrWrite, .flagClrData, .irqFlags,
        .vectorRelocateSelect, .vectorTableBase, .instrBoundary,
        .coreSleeping, .irqBusy, .pcLoad, .pcLoadValue, .irqAckIndex);
    crsi_far_model crsi_far_model_i (.clk_sys, .fire, .irqEvent,
        .stackWrite, .stackAddr, .stackWrData);
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(crsi_wrmode_t m, logic [4:0] a, logic [15:0] d);
        wrMode = m;
        wrAddr = a;
        wrData = d;
        tick();
        wrMode = CRSI_WR_NONE;
        tick();
    endtask
    task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
        ioAddr = a;
        ioWrData = d;
        ioWrite = 1'b1;
        tick();
        ioWrite = 1'b0;
        tick();
    endtask
    task automatic sp(input crsi_spop_t op, input logic [15:0] exp);
        spOp = op;
        tick();
        spOp = CRSI_SP_NONE;
        chk(exp, stackPtr);
        tick();
    endtask
    task automatic pulse_fire(input logic [7:0] m);
        fire = m;
        tick();
        fire = 8'h00;
        tick(5);
    endtask
    // pcLoad stands one cycle, so poll every cycle
    task automatic take(input logic [15:0] vec, input logic [2:0] idx);
        int n;
        n = 0;
        while (pcLoad !== 1'b1 && n < 40)
        begin
            tick();
            n++;
        end
        if (pcLoad !== 1'b1)
        begin
            errors++;
            complete_run();
        end
        chk(vec, pcLoadValue);
        chk({13'h0000, idx}, {13'h0000, irqAckIndex});
        tick();
    endtask
    // first vector 2, step 2 per source; relocation adds the base page
    function automatic logic [15:0] vec_of(input logic [2:0] idx);
        logic [15:0] v;
        v = 16'h0002 + {12'h000, idx, 1'b0};
        if (vectorRelocateSelect)
        begin
            v = {vectorTableBase, 8'h00} + v;
        end
        return v;
    endfunction
    task automatic handler_exit();
        spOp = CRSI_SP_HANDLER_EXIT;
        tick();
        spOp = CRSI_SP_NONE;
        tick(3);
    endtask
    initial
    begin
        int i;
        logic [15:0] w;
        void'($urandom(74));
        tick(8);
        rst_n = 1'b1;
        tick(3);
        chk(16'h08FF, stackPtr);
        ioAddr = 6'h3D;
        #1 chk(16'h00FF, {8'h00, ioRdData});
        for (i = 0; i < 32; i++)
        begin
            w = 16'($urandom);
            wr(CRSI_WR_BYTE, 5'(i), w);
            refReg[i] = w[7:0];
        end
        for (i = 26; i < 32; i += 2)
        begin
            w = 16'($urandom);
            wr(CRSI_WR_WORD, 5'(i), w);
            refReg[i] = w[7:0];
            refReg[i + 1] = w[15:8];
        end
        chk({refReg[27], refReg[26]}, ptrX);
        chk({refReg[29], refReg[28]}, ptrY);
        chk({refReg[31], refReg[30]}, ptrZ);
        rdAddrA = 5'h1A;
        tick();
        for (i = 0; i < 32; i += 2)
        begin
            rdAddrA = 5'(i);
            rdAddrB = 5'(i + 1);
            #1 chk({refReg[i + 1], refReg[i]}, rdWord);
            chk({refReg[i + 1], refReg[i]}, {rdDataB, rdDataA});
            dsRead = 1'b1;
            dsAddr = 16'(i + 1);
            #1 chk({8'h00, refReg[i + 1]}, {8'h00, dsRdData});
            dsRead = 1'b0;
        end
        dsWrite = 1'b1;
        dsAddr = 16'h0005;
        dsWrData = 8'hA5;
        tick();
        dsWrite = 1'b0;
        rdAddrA = 5'h05;
        #1 chk(16'h00A5, {8'h00, rdDataA});
        dsRead = 1'b1;
        dsAddr = 16'h0020;
        #1 chk(16'h0000, {15'h0000, dsHit});
        dsRead = 1'b0;
        io_wr(6'h3D, 8'h40);
        io_wr(6'h3E, 8'h07);
        chk(16'h0740, stackPtr);
        #1 chk(16'h0007, {8'h00, ioRdData});
        io_wr(6'h3D, 8'hFF);
        io_wr(6'h3E, 8'h08);
        pushData = 8'($urandom);
        sp(CRSI_SP_PUSH, 16'h08FE);
        chk({8'h00, pushData}, {8'h00, crsi_far_model_i.mem[16'h08FF]});
        sp(CRSI_SP_POP, 16'h08FF);
        sp(CRSI_SP_CALL, 16'h08FD);
        sp(CRSI_SP_RET, 16'h08FF);
        unmaskAllOp = 1'b1;
        tick();
        unmaskAllOp = 1'b0;
        chk(16'h0001, {15'h0000, globalEnable});
        pulse_fire(8'h22);
        chk(16'h0022, {8'h00, irqFlags});
        flagClrWrite = 1'b1;
        flagClrData = 8'h20;
        tick();
        flagClrWrite = 1'b0;
        chk(16'h0002, {8'h00, irqFlags});
        pulse_fire(8'h20);
        pcNow = 16'($urandom);
        irqEnable = 8'hFF;
        take(vec_of(3'd1), 3'd1);
        chk(16'h0000, {15'h0000, globalEnable});
        chk(16'h0020, {8'h00, irqFlags});
        chk(16'h08FD, stackPtr);
        chk(pcNow, {crsi_far_model_i.mem[16'h08FE], crsi_far_model_i.mem[16'h08FF]});
        instrBoundary = 1'b0;
        handler_exit();
        chk(16'h08FF, stackPtr);
        chk(16'h0001, {15'h0000, globalEnable});
        tick(4);
        chk(16'h0001, {15'h0000, irqBusy});
        vectorRelocateSelect = 1'b1;
        vectorTableBase = 8'h12;
        coreSleeping = 1'b1;
        instrBoundary = 1'b1;
        take(vec_of(3'd5), 3'd5);
        coreSleeping = 1'b0;
        handler_exit();
        maskAllOp = 1'b1;
        fire = 8'h04;
        tick();
        maskAllOp = 1'b0;
        pulse_fire(8'h00);
        chk(16'h0004, {8'h00, irqFlags});
        chk(16'h0000, {15'h0000, irqBusy});
        flagClrWrite = 1'b1;
        flagClrData = 8'h04;
        irqIsLevel = 8'h08;
        irqLevel = 8'h08;
        tick();
        flagClrWrite = 1'b0;
        tick(4);
        irqLevel = 8'h00;
        tick(4);
        // handler code restores the saved flags byte itself
        flagsWrData = 8'h80;
        flagsWrite = 1'b1;
        tick();
        flagsWrite = 1'b0;
        tick(6);
        chk(16'h0000, {15'h0000, irqBusy});
        irqLevel = 8'h08;
        take(vec_of(3'd3), 3'd3);
        irqLevel = 8'h00;
        handler_exit();
        chk(16'h0000, {8'h00, irqFlags});
        complete_run();
    end
endmodule
bind crsi_core crsi_core_checker crsi_core_checker_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .rdAddrA(rdAddrA), .rdWord(rdWord), .ptrX(ptrX),
    .dsRead(dsRead), .dsWrite(dsWrite), .dsAddr(dsAddr), .dsHit(dsHit),
    .ioWrite(ioWrite), .spOp(spOp), .stackPtr(stackPtr),
    .stackWrite(stackWrite), .stackAddr(stackAddr),
    .unmaskAllOp(unmaskAllOp), .maskAllOp(maskAllOp),
    .globalEnable(globalEnable), .coreSleeping(coreSleeping),
    .irqBusy(irqBusy), .pcLoad(pcLoad));
`default_nettype wire
